/* File: damp_pkg.sv */
package damp_pkg;

    // ************************************************************
    // Register map and field layout
    // ************************************************************
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned FREQ_W = 16;
    localparam int unsigned SLOTS = 4;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SLOT1 = 8'h04;
    localparam logic [7:0] ADDR_STEP = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_NOTCH3 = 8'h18;
    localparam logic [7:0] ADDR_NOTCH4 = 8'h1C;
    localparam logic [7:0] ADDR_MEAS1 = 8'h20;
    localparam logic [7:0] ADDR_MEAS2 = 8'h24;
    localparam int unsigned CTRL_SW_LSB = 0;
    localparam int unsigned CTRL_CTL_LSB = 4;
    localparam int unsigned CTRL_AD_LSB = 8;

    // ************************************************************
    // Reset values and limits, frequencies in 0.1 Hz units
    // ************************************************************
    localparam logic [15:0] FREQ_RST = 16'h0000;
    localparam logic [15:0] FREQ_MIN = 16'h000A;
    localparam logic [15:0] FREQ_MAX = 16'h07D0;
    localparam logic [16:0] SUM_MIN = 17'h00064;
    localparam logic [16:0] SUM_CAP = 17'h007D0;
    localparam logic [15:0] NOTCH_OFF = 16'h1388;
    localparam logic [1:0] SLOT_1 = 2'h0;
    localparam logic [1:0] SLOT_2 = 2'h1;
    localparam logic [1:0] SLOT_HIGH = 2'h2;

    // ************************************************************
    // Modes
    // ************************************************************
    typedef enum logic [1:0] {
        SW_FIXED_PAIR,
        SW_ONE_INPUT,
        SW_TWO_INPUTS,
        SW_DIRECTION
    } switch_mode_e;

    typedef enum logic [1:0] {
        CTL_POSITION,
        CTL_SPEED,
        CTL_TORQUE,
        CTL_FULL_CLOSED
    } ctl_mode_e;

    typedef enum logic [2:0] {
        AD_OFF,
        AD_ONE,
        AD_TWO,
        AD_MEASURE,
        AD_CLEAR
    } adapt_mode_e;

    typedef struct packed {
        logic [15:0] shape;
        logic [15:0] freq;
    } slot_cfg_s;

    typedef struct packed {
        logic valid;
        logic [15:0] freq;
        logic [15:0] shape;
    } damp_out_s;

endpackage

/* File: damp_sync.sv */
`timescale 1ns/1ps
module damp_sync #(
    parameter int unsigned W = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // ************************************************************
    // Three-stage capture; the output follows only when the last two agree
    // ************************************************************
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic q_reg;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                    s3_reg <= 1'b0;
                end else begin
                    s1_reg <= d[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    q_reg <= 1'b0;
                end else if (s2_reg == s3_reg) begin
                    q_reg <= s3_reg;
                end
            end
            assign q[i] = q_reg;
        end
    endgenerate

endmodule

/* File: damp_select.sv */
`timescale 1ns/1ps
// How it works
// [RULE1] Damping frequencies are held and passed on in 0.1 Hz units, unscaled.
// [RULE2] A slot is applied only when its frequency lies within 1.0 to 200 Hz.
// [RULE3] No damping in speed or torque control; only position paths are damped.
// [RULE4] Software keeps slot 1 frequency plus setting within 100 and twice frequency or 2000.
// [RULE5] A slot that is not enabled has its filter setting ignored.
// [RULE6] Mode 0 enables slots 1 and 2 regardless of inputs or direction.
// [RULE7] Mode 1: input A open gives slots 1 and 3, shorted gives 2 and 4.
// [RULE8] Mode 2: inputs A and B decode to one slot, 1 to 4.
// [RULE9] Mode 3: forward direction gives slots 1 and 3, reverse gives 2 and 4.
// [RULE10] The controller stops motion before changing parameters or selection inputs.
// [RULE11] Four independent slots, each with frequency and filter setting.
// [RULE12] Adaptive estimates from the speed loop are written into notch 3 and 4.
// [RULE13] Adaptive select: 0 off, 1 one frequency, 2 two frequencies.
// [RULE14] Adaptive select 3 measures resonance without applying it.
// [RULE15] Adaptive select 4 disables notch 3 and 4 and clears stored results.
// [RULE16] A slot frequency of zero marks the slot unused.
// [RULE17] At most two slots are applied at once.
// [RULE18] Selection inputs are synchronised; the active choice changes only at standstill.
module damp_select (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [damp_pkg::ADDR_W-1:0] paddr,
    input wire logic [damp_pkg::DATA_W-1:0] pwdata,
    output logic [damp_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] damp_select_inputs,
    input wire logic cmd_reverse,
    input wire logic axis_stopped,
    input wire logic est_valid,
    input wire logic est_second,
    input wire logic [damp_pkg::FREQ_W-1:0] est_freq,
    output damp_pkg::damp_out_s damp_out_a,
    output damp_pkg::damp_out_s damp_out_b,
    output logic damping_enable,
    output logic adaptive_enable,
    output logic measure_mode,
    output logic [damp_pkg::FREQ_W-1:0] notch3_center_freq,
    output logic [damp_pkg::FREQ_W-1:0] notch4_center_freq
);
    import damp_pkg::*;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ************************************************************
    // Bus handshake
    // ************************************************************
    logic pready_reg;
    logic pslverr_reg;
    logic [DATA_W-1:0] prdata_reg;
    logic rd_take;
    logic wr_take;
    logic hit_ctrl;
    logic hit_status;
    logic hit_notch3;
    logic hit_notch4;
    logic hit_meas1;
    logic hit_meas2;
    logic [SLOTS-1:0] hit_slot;
    logic hit_any;

    // Answer comes one cycle into the access phase; the write lands on the next edge, while pready is high.
    assign rd_take = psel && penable && !pready_reg;
    assign wr_take = psel && penable && pready_reg && pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= rd_take;
        end
    end

    always_comb begin
        hit_ctrl = (paddr == ADDR_CTRL);
        hit_status = (paddr == ADDR_STATUS);
        hit_notch3 = (paddr == ADDR_NOTCH3);
        hit_notch4 = (paddr == ADDR_NOTCH4);
        hit_meas1 = (paddr == ADDR_MEAS1);
        hit_meas2 = (paddr == ADDR_MEAS2);
        for (int i = 0; i < SLOTS; i++) begin
            hit_slot[i] = (paddr == ADDR_SLOT1 + ADDR_STEP * 8'(i));
        end
        hit_any = hit_ctrl || hit_status || hit_notch3 || hit_notch4 || hit_meas1
            || hit_meas2 || (|hit_slot);
    end

    // ************************************************************
    // Parameter registers
    // ************************************************************
    switch_mode_e sw_mode_reg;
    ctl_mode_e ctl_mode_reg;
    logic [2:0] adapt_reg;
    adapt_mode_e adapt_mode;
    slot_cfg_s slot_reg [SLOTS];
    logic position_mode;
    logic torque_mode;

    assign adapt_mode = adapt_mode_e'(adapt_reg);
    assign position_mode = (ctl_mode_reg == CTL_POSITION) || (ctl_mode_reg == CTL_FULL_CLOSED);
    assign torque_mode = (ctl_mode_reg == CTL_TORQUE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_mode_reg <= SW_FIXED_PAIR;
            ctl_mode_reg <= CTL_POSITION;
            adapt_reg <= AD_OFF;
        end else if (wr_take && hit_ctrl) begin
            sw_mode_reg <= switch_mode_e'(pwdata[CTRL_SW_LSB +: 2]);
            ctl_mode_reg <= ctl_mode_e'(pwdata[CTRL_CTL_LSB +: 2]);
            adapt_reg <= pwdata[CTRL_AD_LSB +: 3];
        end
    end

    genvar g;
    generate
        for (g = 0; g < SLOTS; g++) begin : g_slot
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    slot_reg[g] <= '{shape: FREQ_RST, freq: FREQ_RST}; // RULE11
                end else if (wr_take && hit_slot[g]) begin
                    slot_reg[g] <= slot_cfg_s'(pwdata); // RULE1
                end
            end
        end
    endgenerate

    // ************************************************************
    // Slot choice
    // ************************************************************
    logic [1:0] sync_sel;
    logic damp_select_input_a;
    logic damp_select_input_b;
    logic [1:0] want_a;
    logic [1:0] want_b;
    logic want_use_b;
    logic [1:0] act_a_reg;
    logic [1:0] act_b_reg;
    logic use_b_reg;
    logic [SLOTS-1:0] in_band;

    damp_sync #(.W(2)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(damp_select_inputs),
        .q(sync_sel)
    ); // RULE18

    assign damp_select_input_a = sync_sel[0];
    assign damp_select_input_b = sync_sel[1];

    always_comb begin
        for (int i = 0; i < SLOTS; i++) begin
            in_band[i] = (slot_reg[i].freq >= FREQ_MIN) && (slot_reg[i].freq <= FREQ_MAX); // RULE2 RULE16
        end
    end

    always_comb begin
        want_a = SLOT_1;
        want_b = SLOT_2;
        want_use_b = 1'b1;
        unique case (sw_mode_reg)
            SW_FIXED_PAIR: begin
                want_a = SLOT_1; // RULE6
                want_b = SLOT_2;
            end
            SW_ONE_INPUT: begin
                want_a = {1'b0, damp_select_input_a}; // RULE7
                want_b = SLOT_HIGH | {1'b0, damp_select_input_a};
            end
            SW_TWO_INPUTS: begin
                want_a = {damp_select_input_b, damp_select_input_a}; // RULE8
                want_use_b = 1'b0;
            end
            SW_DIRECTION: begin
                want_a = {1'b0, cmd_reverse}; // RULE9
                want_b = SLOT_HIGH | {1'b0, cmd_reverse};
            end
        endcase
    end

    // Switching while moving would step the command shaping mid-profile, so wait for standstill.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_a_reg <= SLOT_1;
            act_b_reg <= SLOT_2;
            use_b_reg <= 1'b1;
        end else if (axis_stopped) begin
            act_a_reg <= want_a; // RULE18
            act_b_reg <= want_b;
            use_b_reg <= want_use_b;
        end
    end

    // ************************************************************
    // Applied damping, two lanes only
    // ************************************************************
    damp_out_s out_a_reg;
    damp_out_s out_b_reg;
    logic enable_reg;
    logic a_ok;
    logic b_ok;

    assign a_ok = position_mode && in_band[act_a_reg]; // RULE3
    assign b_ok = position_mode && use_b_reg && in_band[act_b_reg];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_a_reg <= '0;
            out_b_reg <= '0;
            enable_reg <= 1'b0;
        end else begin
            enable_reg <= position_mode; // RULE3
            out_a_reg.valid <= a_ok; // RULE17
            out_a_reg.freq <= a_ok ? slot_reg[act_a_reg].freq : FREQ_RST;
            out_a_reg.shape <= a_ok ? slot_reg[act_a_reg].shape : FREQ_RST; // RULE5
            out_b_reg.valid <= b_ok;
            out_b_reg.freq <= b_ok ? slot_reg[act_b_reg].freq : FREQ_RST;
            out_b_reg.shape <= b_ok ? slot_reg[act_b_reg].shape : FREQ_RST; // RULE5
        end
    end

    // Software owns the setting range; the block only reports a breach for slot 1.
    logic [16:0] s1_sum;
    logic [16:0] s1_cap;
    logic s1_range_bad;
    always_comb begin
        s1_sum = {1'b0, slot_reg[0].freq} + {1'b0, slot_reg[0].shape};
        s1_cap = {slot_reg[0].freq, 1'b0};
        if (s1_cap > SUM_CAP) begin
            s1_cap = SUM_CAP;
        end
        s1_range_bad = in_band[0] && ((s1_sum < SUM_MIN) || (s1_sum > s1_cap)); // RULE4
    end

    // ************************************************************
    // Adaptive notch control
    // ************************************************************
    logic [FREQ_W-1:0] notch3_reg;
    logic [FREQ_W-1:0] notch4_reg;
    logic [FREQ_W-1:0] meas_reg [2];
    logic [1:0] meas_valid_reg;
    logic est_ok;
    logic est_to3;
    logic est_to4;
    logic adapt_en_reg;
    logic measure_reg;

    // Estimates are frozen in torque control so the last notch stays in force.
    assign est_ok = est_valid && !torque_mode;
    assign est_to3 = est_ok && !est_second && (adapt_mode == AD_ONE || adapt_mode == AD_TWO);
    assign est_to4 = est_ok && est_second && (adapt_mode == AD_TWO); // RULE13

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            notch3_reg <= NOTCH_OFF;
        end else if (adapt_mode == AD_CLEAR) begin
            notch3_reg <= NOTCH_OFF; // RULE15
        end else if (est_to3) begin
            notch3_reg <= est_freq; // RULE12
        end else if (wr_take && hit_notch3) begin
            notch3_reg <= pwdata[FREQ_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            notch4_reg <= NOTCH_OFF;
        end else if (adapt_mode == AD_CLEAR) begin
            notch4_reg <= NOTCH_OFF; // RULE15
        end else if (est_to4) begin
            notch4_reg <= est_freq; // RULE12
        end else if (wr_take && hit_notch4) begin
            notch4_reg <= pwdata[FREQ_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meas_reg[0] <= FREQ_RST;
            meas_reg[1] <= FREQ_RST;
            meas_valid_reg <= 2'h0;
        end else if (adapt_mode == AD_CLEAR) begin
            meas_reg[0] <= FREQ_RST; // RULE15
            meas_reg[1] <= FREQ_RST;
            meas_valid_reg <= 2'h0;
        end else if (adapt_mode == AD_MEASURE && est_ok) begin
            meas_reg[est_second] <= est_freq; // RULE14
            meas_valid_reg[est_second] <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adapt_en_reg <= 1'b0;
            measure_reg <= 1'b0;
        end else begin
            adapt_en_reg <= !torque_mode && (adapt_mode == AD_ONE || adapt_mode == AD_TWO);
            measure_reg <= (adapt_mode == AD_MEASURE); // RULE14
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    logic [DATA_W-1:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        if (hit_ctrl) begin
            rd_mux[CTRL_SW_LSB +: 2] = sw_mode_reg;
            rd_mux[CTRL_CTL_LSB +: 2] = ctl_mode_reg;
            rd_mux[CTRL_AD_LSB +: 3] = adapt_reg;
        end else if (hit_status) begin
            rd_mux[13:0] = {meas_valid_reg, in_band, s1_range_bad, out_b_reg.valid,
                out_a_reg.valid, act_b_reg, act_a_reg, axis_stopped};
        end else if (hit_notch3) begin
            rd_mux[FREQ_W-1:0] = notch3_reg;
        end else if (hit_notch4) begin
            rd_mux[FREQ_W-1:0] = notch4_reg;
        end else if (hit_meas1) begin
            rd_mux[FREQ_W-1:0] = meas_reg[0];
        end else if (hit_meas2) begin
            rd_mux[FREQ_W-1:0] = meas_reg[1];
        end else begin
            for (int i = 0; i < SLOTS; i++) begin
                if (hit_slot[i]) begin
                    rd_mux = slot_reg[i];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= '0;
            pslverr_reg <= 1'b0;
        end else if (rd_take) begin
            prdata_reg <= pwrite ? '0 : rd_mux;
            pslverr_reg <= !hit_any;
        end else begin
            pslverr_reg <= 1'b0;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign damp_out_a = out_a_reg;
    assign damp_out_b = out_b_reg;
    assign damping_enable = enable_reg;
    assign adaptive_enable = adapt_en_reg;
    assign measure_mode = measure_reg;
    assign notch3_center_freq = notch3_reg;
    assign notch4_center_freq = notch4_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    AST_FREQ_UNIT: assert property ( // RULE1
        damp_out_a.valid |-> damp_out_a.freq == $past(slot_reg[act_a_reg].freq))
        else $error("Applied frequency differs from the stored slot value.");

    AST_BAND_ONLY: assert property ( // RULE2
        damp_out_a.valid |-> damp_out_a.freq >= FREQ_MIN && damp_out_a.freq <= FREQ_MAX)
        else $error("Applied frequency lies outside the usable band.");

    AST_NO_DAMP_SPEED_TORQUE: assert property ( // RULE3
        (ctl_mode_reg == CTL_SPEED || ctl_mode_reg == CTL_TORQUE)
        |=> !damping_enable && !damp_out_a.valid && !damp_out_b.valid)
        else $error("Damping applied outside position control.");

    AST_SHAPE_IGNORED: assert property ( // RULE5
        !damp_out_b.valid |-> damp_out_b.shape == FREQ_RST)
        else $error("Filter setting passed for a disabled slot.");

    AST_FIXED_PAIR: assert property ( // RULE6
        sw_mode_reg == SW_FIXED_PAIR && axis_stopped
        |=> act_a_reg == SLOT_1 && act_b_reg == SLOT_2 && use_b_reg)
        else $error("Mode 0 did not select slots 1 and 2.");

    AST_ONE_INPUT: assert property ( // RULE7
        sw_mode_reg == SW_ONE_INPUT && axis_stopped
        |=> act_a_reg == {1'b0, $past(sync_sel[0])} && act_b_reg[1] && use_b_reg)
        else $error("Mode 1 slot pair does not follow input A.");

    AST_TWO_INPUTS: assert property ( // RULE8
        sw_mode_reg == SW_TWO_INPUTS && axis_stopped
        |=> act_a_reg == $past(sync_sel) && !use_b_reg)
        else $error("Mode 2 slot does not follow inputs A and B.");

    AST_DIRECTION: assert property ( // RULE9
        sw_mode_reg == SW_DIRECTION && axis_stopped
        |=> act_a_reg == {1'b0, $past(cmd_reverse)} && act_b_reg == {1'b1, $past(cmd_reverse)})
        else $error("Mode 3 slot pair does not follow direction.");

    AST_UNUSED_SLOT: assert property ( // RULE16
        (position_mode && slot_reg[act_a_reg].freq == FREQ_RST) |=> !damp_out_a.valid)
        else $error("Slot with zero frequency was applied.");

    AST_HOLD_MOVING: assert property ( // RULE18
        !axis_stopped |=> $stable(act_a_reg) && $stable(act_b_reg) && $stable(use_b_reg))
        else $error("Active slot changed while the axis moved.");

    AST_ADAPT_WRITE: assert property ( // RULE12
        est_to3 && adapt_mode == AD_ONE |=> notch3_center_freq == $past(est_freq))
        else $error("Estimate not written into notch 3.");

    AST_ONE_KEEPS_N4: assert property ( // RULE13
        adapt_mode == AD_ONE && !(wr_take && hit_notch4) |=> $stable(notch4_center_freq))
        else $error("Notch 4 changed with one adaptive filter.");

    AST_MEASURE_ONLY: assert property ( // RULE14
        adapt_mode == AD_MEASURE && est_ok && !(wr_take && hit_notch3)
        |=> $stable(notch3_center_freq) && meas_valid_reg[$past(est_second)])
        else $error("Measurement mode applied or lost an estimate.");

    AST_ADAPT_CLEAR: assert property ( // RULE15
        adapt_mode == AD_CLEAR |=> notch3_center_freq == NOTCH_OFF
        && notch4_center_freq == NOTCH_OFF && meas_valid_reg == 2'h0)
        else $error("Adaptive clear did not reset notch 3, notch 4 and results.");

    COV_PAIR_APPLIED: cover property (damp_out_a.valid && damp_out_b.valid);
    COV_SINGLE_SLOT4: cover property (sw_mode_reg == SW_TWO_INPUTS && act_a_reg == 2'h3);
    COV_REVERSE_PAIR: cover property (sw_mode_reg == SW_DIRECTION && act_b_reg == 2'h3);
    COV_TWO_NOTCHES: cover property (est_to4 ##1 adapt_mode == AD_CLEAR);

endmodule

/* File: damp_far_side.sv */
`timescale 1ns/1ps
module damp_far_side (
    input wire logic pclk,
    input wire logic [1:0] want_sel,
    input wire logic want_rev,
    input wire logic want_stop,
    input wire logic misbehave,
    output logic [1:0] damp_select_inputs,
    output logic cmd_reverse,
    output logic axis_stopped
);
    // ************************************************************
    // Contacts, command direction and standstill
    // ************************************************************
    initial begin
        damp_select_inputs = 2'h0;
        cmd_reverse = 1'b0;
        axis_stopped = 1'b1;
    end

    // A careful controller moves contacts only at standstill; misbehave lets one scenario
    // flip them while moving to prove the drive holds its choice.
    always @(posedge pclk) begin
        axis_stopped <= want_stop;
        if ((axis_stopped && want_stop) || misbehave) begin
            damp_select_inputs <= want_sel;
            cmd_reverse <= want_rev;
        end
    end
endmodule

/* File: damping_filter_select_adaptive_notch_test.sv */
`timescale 1ns/1ps
module damping_filter_select_adaptive_notch_test;
    import damp_pkg::*;
    // ************************************************************
    // Bench signals and reference state
    // ************************************************************
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic est_valid = 1'b0;
    logic est_second = 1'b0;
    logic [15:0] est_freq = 16'h0000;
    logic [1:0] want_sel = 2'h0;
    logic want_rev = 1'b0;
    logic want_stop = 1'b1;
    logic misbehave = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] pins;
    logic rev;
    logic stopped;
    damp_out_s out_a;
    damp_out_s out_b;
    logic den;
    logic aen;
    logic mmode;
    logic [15:0] n3;
    logic [15:0] n4;
    logic [31:0] rd;
    logic er;
    int err_total = 0;
    int compares = 0;
    int fq[4] = '{100, 2001, 2000, 0};
    int sh[4];
    int n3x = NOTCH_OFF;
    int n4x = NOTCH_OFF;

    initial begin
        forever #25 pclk = ~pclk;
    end

    damp_select i_damp_select (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .damp_select_inputs(pins), .cmd_reverse(rev), .axis_stopped(stopped),
        .est_valid(est_valid), .est_second(est_second), .est_freq(est_freq),
        .damp_out_a(out_a), .damp_out_b(out_b), .damping_enable(den), .adaptive_enable(aen),
        .measure_mode(mmode), .notch3_center_freq(n3), .notch4_center_freq(n4));
    damp_far_side i_damp_far_side (.pclk(pclk), .want_sel(want_sel), .want_rev(want_rev),
        .want_stop(want_stop), .misbehave(misbehave), .damp_select_inputs(pins),
        .cmd_reverse(rev), .axis_stopped(stopped));

    task automatic test_done();
        if (err_total == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_total++;
            test_done();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Out-of-band slots, zero included, are expected dark rather than half applied.
    function automatic damp_out_s ex(input int s, input bit on);
        ex = '0;
        if (on && s >= 0 && fq[s] >= 10 && fq[s] <= 2000) begin
            ex = {1'b1, 16'(fq[s]), 16'(sh[s])};
        end
    endfunction

    // Contact model, pin sync, latch and output stage take seven edges; eight leaves one spare.
    task automatic look(input int sa, input int sb, input bit on);
        repeat (8) @(posedge pclk);
        chk("out_a", out_a, ex(sa, on));
        chk("out_b", out_b, ex(sb, on));
    endtask

    task automatic est(input logic sec, input logic [15:0] f);
        est_valid <= 1'b1;
        est_second <= sec;
        est_freq <= f;
        @(posedge pclk);
        est_valid <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask

    initial begin
        int sa;
        void'($urandom(40));
        sh[0] = $urandom % 101;
        for (int i = 1; i < 4; i++) begin
            sh[i] = $urandom % 65536;
        end
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("notch3", 33'(n3), 33'(NOTCH_OFF));
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 8'(ADDR_SLOT1 + ADDR_STEP * i), {16'(sh[i]), 16'(fq[i])});
            apb(1'b0, 8'(ADDR_SLOT1 + ADDR_STEP * i), 32'h0);
            chk("slot", 33'(rd), 33'({16'(sh[i]), 16'(fq[i])}));
        end
        for (int m = 0; m < 4; m++) begin
            for (int p = 0; p < 4; p++) begin
                apb(1'b1, ADDR_CTRL, 32'(m));
                want_sel <= 2'(p);
                want_rev <= p[0];
                sa = (m == 2) ? p : ((m == 0 || !p[0]) ? 0 : 1);
                look(sa, (m == 2) ? -1 : sa + ((m == 0) ? 1 : 2), 1'b1);
            end
        end
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, ADDR_CTRL, 32'(c) << 4);
            look(0, 1, c == 0 || c == 3);
            chk("den", 33'(den), 33'(c == 0 || c == 3));
        end
        apb(1'b1, ADDR_CTRL, 32'h1);
        want_sel <= 2'h0;
        look(0, 2, 1'b1);
        want_stop <= 1'b0;
        misbehave <= 1'b1;
        repeat (2) @(posedge pclk);
        want_sel <= 2'h1;
        look(0, 2, 1'b1);
        want_stop <= 1'b1;
        misbehave <= 1'b0;
        look(1, 3, 1'b1);
        for (int a = 0; a < 5; a++) begin
            apb(1'b1, ADDR_CTRL, 32'(a) << 8);
            est(1'b0, 16'(300 + a));
            est(1'b1, 16'(600 + a));
            n3x = (a == 1 || a == 2) ? 300 + a : ((a == 4) ? NOTCH_OFF : n3x);
            n4x = (a == 2) ? 600 + a : ((a == 4) ? NOTCH_OFF : n4x);
            chk("notch3", 33'(n3), 33'(n3x));
            chk("notch4", 33'(n4), 33'(n4x));
            chk("adapt", 33'(aen), 33'(a == 1 || a == 2));
            chk("measure", 33'(mmode), 33'(a == 3));
            if (a >= 3) begin
                apb(1'b0, ADDR_MEAS1, 32'h0);
                chk("meas1", 33'(rd[15:0]), 33'((a == 3) ? 303 : 0));
                apb(1'b0, ADDR_MEAS2, 32'h0);
                chk("meas2", 33'(rd[15:0]), 33'((a == 3) ? 603 : 0));
            end
        end
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("status", 33'(rd), 33'(32'h0000_0529));
        apb(1'b0, 8'h40, 32'h0);
        chk("slverr", 33'(er), 33'(1));
        test_done();
    end
endmodule
